// ### dsg_defs.vh
// Offsets, field positions, reset values and masks for the gating block
`ifndef DSG_DEFS_VH
`define DSG_DEFS_VH

// Register byte offsets
`define DSG_OFF_SOFT_RST0     12'h040
`define DSG_OFF_RUN_CFG       12'h060
`define DSG_OFF_RUN_GATE2     12'h108
`define DSG_OFF_SLEEP_GATE2   12'h118
`define DSG_OFF_DEEP_GATE2    12'h128
`define DSG_OFF_INT_STATUS    12'h150
`define DSG_OFF_INT_MASK      12'h154

// Field positions
`define DSG_BIT_CAN_RST       24
`define DSG_BIT_WDOG_RST      3
`define DSG_BIT_ACG           0
`define DSG_BIT_EV_FAULT      0
`define DSG_BIT_EV_RESET      1

// Writable bits of each register; everything else reads zero
`define DSG_MASK_GATE         32'h0000_00ff
`define DSG_MASK_SOFT_RST0    32'h0100_0008
`define DSG_MASK_RUN_CFG      32'h0000_0001
`define DSG_MASK_INT          32'h0000_0003

// Reset values
`define DSG_RST_GATE          8'h00
`define DSG_RST_SOFT_RST0     32'h0000_0000

// Power modes
`define DSG_MODE_RUN          2'h0
`define DSG_MODE_SLEEP        2'h1
`define DSG_MODE_DEEP         2'h2

`endif

// ### dsg_gate_sel.v
// Picks the active gating word by power mode and flags gated accesses
`timescale 1ns/1ps
`include "dsg_defs.vh"

module dsg_gate_sel #(
	parameter NPORT = 8
) (
	input  wire             clk_sys,
	input  wire             sys_rst,
	input  wire [NPORT-1:0] run_gate,     // Run-mode enables
	input  wire [NPORT-1:0] sleep_gate,   // Sleep-mode enables
	input  wire [NPORT-1:0] deep_gate,    // Deep-sleep enables
	input  wire             acg_en,       // Auto gating enable
	input  wire [1:0]       mode,         // Current power mode
	input  wire [NPORT-1:0] port_access,  // Access strobe per port
	output reg  [NPORT-1:0] clk_en_r,     // Registered clock enables
	output reg              fault_r       // One-cycle fault pulse
);

	// Sleep words only count when auto gating is on
	reg [NPORT-1:0] en_nxt;

	// ----------------------------------------
	// Mode selection
	// ----------------------------------------
	always @*
	begin
		en_nxt = run_gate;
		if (acg_en && mode == `DSG_MODE_DEEP)
			en_nxt = deep_gate;
		else if (acg_en && mode == `DSG_MODE_SLEEP)
			en_nxt = sleep_gate;
	end

	// ----------------------------------------
	// Enable register and fault detect
	// ----------------------------------------
	// Fault is checked against the enable in force now, not the next one
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			clk_en_r <= {NPORT{1'b0}};
			fault_r  <= 1'b0;
		end
		else
		begin
			clk_en_r <= en_nxt;
			fault_r  <= |(port_access & ~clk_en_r);
		end
	end

endmodule

// ### dsg_irq.v
// Sticky event status with mask and one level interrupt
`timescale 1ns/1ps

module dsg_irq #(
	parameter NEV = 2
) (
	input  wire           clk_sys,
	input  wire           sys_rst,
	input  wire [NEV-1:0] event_in,    // Event pulses
	input  wire [NEV-1:0] clr_bits,    // Write-one-to-clear strobes
	input  wire           mask_we,     // Mask write strobe
	input  wire [NEV-1:0] mask_wdata,  // Mask write data
	output reg  [NEV-1:0] status_r,    // Sticky status
	output reg  [NEV-1:0] mask_r,      // Enable mask
	output reg            irq_r        // Level interrupt
);

	// Status value for the coming edge
	wire [NEV-1:0] status_nxt;

	// A set in the clear cycle wins so no event is lost
	assign status_nxt = (status_r & ~clr_bits) | event_in;

	// ----------------------------------------
	// Status, mask and interrupt
	// ----------------------------------------
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			status_r <= {NEV{1'b0}};
			mask_r   <= {NEV{1'b0}};
			irq_r    <= 1'b0;
		end
		else
		begin
			status_r <= status_nxt;
			if (mask_we)
				mask_r <= mask_wdata;
			irq_r <= |(status_nxt & (mask_we ? mask_wdata : mask_r));
		end
	end

endmodule

// ### dsg_top.v
// Deep-sleep clock gating and software reset control with AHB-Lite slave
`timescale 1ns/1ps
`include "dsg_defs.vh"

module dsg_top #(
	parameter NPORT = 8
) (
	input  wire             clk_sys,
	input  wire             sys_rst,
	input  wire             hsel,
	input  wire [11:0]      haddr,
	input  wire [1:0]       htrans,
	input  wire             hwrite,
	input  wire [2:0]       hsize,
	input  wire [31:0]      hwdata,
	input  wire             hready,
	output reg              hreadyout,
	output reg              hresp,
	output reg  [31:0]      hrdata,
	input  wire [31:0]      capabilities_1,
	input  wire             sys_sleep,
	input  wire             sys_deep_sleep,
	input  wire [NPORT-1:0] port_access,
	output wire [NPORT-1:0] port_clk_en,
	output wire             port_bus_fault,
	output reg              can_unit_reset,
	output reg              watchdog_reset,
	output wire             irq
);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	reg  [NPORT-1:0] run_clock_gate_2_r;        // Run-mode enables
	reg  [NPORT-1:0] sleep_clock_gate_2_r;      // Sleep-mode enables
	reg  [NPORT-1:0] deep_sleep_clock_gate_2_r; // Deep-sleep enables
	reg  [31:0]      soft_reset_ctrl_0_r;       // Software reset bits
	reg              auto_clock_gating_bit_r;   // Auto gating enable
	reg              wr_pend_r;                 // Write data phase due
	reg  [11:0]      wr_addr_r;                 // Latched write address

	// Next values, also used for read-back so a read right after
	// a write sees the new contents
	reg  [NPORT-1:0] run_nxt;
	reg  [NPORT-1:0] sleep_nxt;
	reg  [NPORT-1:0] deep_nxt;
	reg  [31:0]      srst_nxt;
	reg              acg_nxt;
	reg  [1:0]       mode;                      // Current power mode
	reg  [1:0]       clr_bits;                  // Status clear strobes
	reg              mask_we;                   // Mask write strobe

	wire             addr_ok;                   // Address phase taken
	wire [1:0]       status;
	wire [1:0]       mask;
	wire [1:0]       ev;
	wire             fault_pulse;
	wire [11:0]      rd_addr;                   // Word address of a read

	// Two events: gated access fault and soft reset raised
	localparam NEV = 2;

	// ----------------------------------------
	// Register map (byte offsets, whole words)
	// ----------------------------------------
	// 0x040  soft_reset_ctrl_0: bit 24 CAN unit, bit 3 watchdog
	// 0x060  run_clock_config: bit 0 auto gating enable
	// 0x108  run_clock_gate_2: port enables while running
	// 0x118  sleep_clock_gate_2: port enables in sleep
	// 0x128  deep_sleep_clock_gate_2: port enables in deep sleep
	// 0x150  event status, write one to clear a bit
	// 0x154  event mask, same layout as the status
	// Any other offset reads zero and drops writes. The bus answer
	// stays OKAY: the gated ports sit outside this block, so their
	// fault is reported on its own pin instead.
	// hsize is not decoded; software only moves whole words here.

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Masked update: only bits in keep may change
	function [31:0] merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [31:0] keep;
		begin
			merge = (old_v & ~keep) | (new_v & keep);
		end
	endfunction

	// Pads a gating word into a bus word, upper bits zero
	function [31:0] gword;
		input [NPORT-1:0] g;
		begin
			gword = {{(32-NPORT){1'b0}}, g} & `DSG_MASK_GATE;
		end
	endfunction

	// Word address of a bus byte address; the two low bits select
	// nothing because every register is one whole word
	function [11:0] word_addr;
		input [11:0] a;
		begin
			word_addr = {a[11:2], 2'b00};
		end
	endfunction

	assign addr_ok = hsel & hready & htrans[1];
	assign rd_addr = word_addr(haddr);

	// ----------------------------------------
	// Power mode decode
	// ----------------------------------------
	// Deep sleep takes priority when both requests are high
	// Both sleep inputs come from the power controller, in step
	// with the clock, so no synchroniser is needed here
	always @*
	begin
		if (sys_deep_sleep)
			mode = `DSG_MODE_DEEP;
		else if (sys_sleep)
			mode = `DSG_MODE_SLEEP;
		else
			mode = `DSG_MODE_RUN;
	end

	// ----------------------------------------
	// Write decode in the data phase
	// ----------------------------------------
	always @*
	begin
		run_nxt   = run_clock_gate_2_r;
		sleep_nxt = sleep_clock_gate_2_r;
		deep_nxt  = deep_sleep_clock_gate_2_r;
		srst_nxt  = soft_reset_ctrl_0_r;
		acg_nxt   = auto_clock_gating_bit_r;
		clr_bits  = 2'h0;
		mask_we   = 1'b0;
		// A write lands at the end of its data phase, once hwdata is
		// valid on the bus
		if (wr_pend_r)
		begin
			// Bits outside each field mask are dropped here
			if (wr_addr_r == `DSG_OFF_DEEP_GATE2)
				deep_nxt = hwdata[NPORT-1:0];
			else if (wr_addr_r == `DSG_OFF_SLEEP_GATE2)
				sleep_nxt = hwdata[NPORT-1:0];
			else if (wr_addr_r == `DSG_OFF_RUN_GATE2)
				run_nxt = hwdata[NPORT-1:0];
			else if (wr_addr_r == `DSG_OFF_SOFT_RST0)
				// Absent units and reserved bits keep zero
				srst_nxt = merge(soft_reset_ctrl_0_r, hwdata,
					capabilities_1 & `DSG_MASK_SOFT_RST0);
			else if (wr_addr_r == `DSG_OFF_RUN_CFG)
				acg_nxt = hwdata[`DSG_BIT_ACG];
			else if (wr_addr_r == `DSG_OFF_INT_STATUS)
				clr_bits = hwdata[1:0];
			else if (wr_addr_r == `DSG_OFF_INT_MASK)
				mask_we = 1'b1;
		end
	end

	// ----------------------------------------
	// Register update and bus phase tracking
	// ----------------------------------------
	// Zero wait states: every transfer completes in one data phase
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			run_clock_gate_2_r        <= `DSG_RST_GATE;
			sleep_clock_gate_2_r      <= `DSG_RST_GATE;
			deep_sleep_clock_gate_2_r <= `DSG_RST_GATE;
			soft_reset_ctrl_0_r       <= `DSG_RST_SOFT_RST0;
			auto_clock_gating_bit_r   <= 1'b0;
			wr_pend_r                 <= 1'b0;
			wr_addr_r                 <= 12'h000;
			hreadyout                 <= 1'b1;
			hresp                     <= 1'b0;
		end
		else
		begin
			run_clock_gate_2_r        <= run_nxt;
			sleep_clock_gate_2_r      <= sleep_nxt;
			deep_sleep_clock_gate_2_r <= deep_nxt;
			soft_reset_ctrl_0_r       <= srst_nxt;
			auto_clock_gating_bit_r   <= acg_nxt;
			wr_pend_r                 <= addr_ok & hwrite;
			// Word aligned: low address bits are ignored
			if (addr_ok)
				wr_addr_r <= word_addr(haddr);
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// ----------------------------------------
	// Read data, loaded at the address phase
	// ----------------------------------------
	// Unmapped addresses read as zero with an OKAY answer
	always @(posedge clk_sys)
	begin
		if (sys_rst)
			hrdata <= 32'h0000_0000;
		else if (addr_ok && !hwrite)
		begin
			// Next values of the gate, reset and config words are read so a read taken
			// in the data phase of a write there already sees what that write stored
			if (rd_addr == `DSG_OFF_DEEP_GATE2)
				hrdata <= gword(deep_nxt);
			else if (rd_addr == `DSG_OFF_SLEEP_GATE2)
				hrdata <= gword(sleep_nxt);
			else if (rd_addr == `DSG_OFF_RUN_GATE2)
				hrdata <= gword(run_nxt);
			else if (rd_addr == `DSG_OFF_SOFT_RST0)
				hrdata <= srst_nxt & `DSG_MASK_SOFT_RST0;
			else if (rd_addr == `DSG_OFF_RUN_CFG)
				hrdata <= {31'h0000_0000, acg_nxt};
			else if (rd_addr == `DSG_OFF_INT_STATUS)
				hrdata <= {30'h0000_0000, status};
			else if (rd_addr == `DSG_OFF_INT_MASK)
				hrdata <= {30'h0000_0000, mask};
			else
				hrdata <= 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Unit reset outputs
	// ----------------------------------------
	// Held for as long as the bit stays set; cleared bit releases
	// Loaded from the next value so each pin moves at the same edge
	// as its register bit, one edge ahead of the gating outputs
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			can_unit_reset <= 1'b0;
			watchdog_reset <= 1'b0;
		end
		else
		begin
			can_unit_reset <= srst_nxt[`DSG_BIT_CAN_RST];
			watchdog_reset <= srst_nxt[`DSG_BIT_WDOG_RST];
		end
	end

	// ----------------------------------------
	// Gating selection and fault detect
	// ----------------------------------------
	// The enables are registered in the selector, so a mode change
	// reaches port_clk_en one edge after the inputs move
	dsg_gate_sel #(
		.NPORT       (NPORT)
	) u_gate (
		.clk_sys     (clk_sys),
		.sys_rst     (sys_rst),
		.run_gate    (run_clock_gate_2_r),
		.sleep_gate  (sleep_clock_gate_2_r),
		.deep_gate   (deep_sleep_clock_gate_2_r),
		.acg_en      (auto_clock_gating_bit_r),
		.mode        (mode),
		.port_access (port_access),
		.clk_en_r    (port_clk_en),
		.fault_r     (fault_pulse)
	);

	assign port_bus_fault = fault_pulse;

	// ----------------------------------------
	// Interrupt events
	// ----------------------------------------
	// Event 1 fires on any write that raises a unit reset bit
	// Writing one to a bit that is already set raises no event
	assign ev[`DSG_BIT_EV_FAULT] = fault_pulse;
	assign ev[`DSG_BIT_EV_RESET] = |(srst_nxt & ~soft_reset_ctrl_0_r);

	dsg_irq #(
		.NEV        (NEV)
	) u_irq (
		.clk_sys    (clk_sys),
		.sys_rst    (sys_rst),
		.event_in   (ev),
		.clr_bits   (clr_bits),
		.mask_we    (mask_we),
		.mask_wdata (hwdata[1:0]),
		.status_r   (status),
		.mask_r     (mask),
		.irq_r      (irq)
	);

endmodule

// ### dsg_top_monitor.sv
// Concurrent port checks for the gating and soft reset block
`timescale 1ns/1ps
module dsg_top_monitor #(
	parameter NPORT = 8
) (
	input wire logic             clk_sys,
	input wire logic             sys_rst,
	input wire logic             hsel,
	input wire logic [11:0]      haddr,
	input wire logic [1:0]       htrans,
	input wire logic             hwrite,
	input wire logic [31:0]      hwdata,
	input wire logic             hready,
	input wire logic             hresp,
	input wire logic [31:0]      hrdata,
	input wire logic [31:0]      capabilities_1,
	input wire logic [NPORT-1:0] port_access,
	input wire logic [NPORT-1:0] port_clk_en,
	input wire logic             port_bus_fault,
	input wire logic             can_unit_reset,
	input wire logic             watchdog_reset,
	input wire logic             irq
);
	// ----------------------------------------
	// Clocking
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	// Read address phase taken this edge
	wire rd_go = hsel && hready && htrans[1] && !hwrite;
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_fault_gated: assert property (
		(port_access & ~port_clk_en) != 0 |=> port_bus_fault)
		else $error("no fault on gated access");
	a_fault_clean: assert property (
		(port_access & ~port_clk_en) == 0 |=> !port_bus_fault)
		else $error("fault on clocked access");
	a_bus_okay: assert property (!hresp)
		else $error("bus response not okay");
	a_gate_reserved: assert property (
		rd_go && haddr[11:2] == 10'h04a |=> hrdata[31:8] == 24'h0)
		else $error("gate reserved bits set");
	a_rst_reserved: assert property (
		rd_go && haddr[11:2] == 10'h010 |=> (hrdata & ~32'h0100_0008) == 0)
		else $error("reset reserved bits set");
	a_gate_cold: assert property (
		$past(sys_rst) |-> port_clk_en == 0 && !irq)
		else $error("enables not clear after reset");
	a_can_masked: assert property (
		$rose(can_unit_reset) |-> $past(capabilities_1[24] & hwdata[24]))
		else $error("can reset set without cause");
	a_wdog_masked: assert property (
		$rose(watchdog_reset) |-> $past(capabilities_1[3] & hwdata[3]))
		else $error("watchdog reset set without cause");
endmodule

bind dsg_top dsg_top_monitor #(.NPORT(NPORT)) u_mon (.clk_sys(clk_sys),
	.sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hresp(hresp),
	.hrdata(hrdata), .capabilities_1(capabilities_1),
	.port_access(port_access), .port_clk_en(port_clk_en),
	.port_bus_fault(port_bus_fault), .can_unit_reset(can_unit_reset),
	.watchdog_reset(watchdog_reset), .irq(irq));

// ### tb_deep_sleep_gating_and_soft_reset.sv
// Self-checking bench for the gating and soft reset block
`timescale 1ns/1ps
module tb_deep_sleep_gating_and_soft_reset;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic        clk_sys = 0, sys_rst = 1, hsel = 0, hwrite = 0;
	logic        sys_sleep = 0, sys_deep_sleep = 0, rd_ph = 0;
	logic [11:0] haddr = 0;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 0, capabilities_1 = 0, d, c;
	logic [7:0]  port_access = 0;
	logic [31:0] exp_q[$];  // Expected read data, oldest first
	wire         hready, hreadyout, hresp, port_bus_fault, irq;
	wire         can_unit_reset, watchdog_reset;
	wire [31:0]  hrdata;
	wire [7:0]   port_clk_en;
	int          n_fail = 0, compares = 0, i;
	assign hready = hreadyout;  // Single slave drives the bus ready
	always #5 clk_sys = ~clk_sys;
	dsg_top #(.NPORT(8)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.capabilities_1(capabilities_1), .sys_sleep(sys_sleep),
		.sys_deep_sleep(sys_deep_sleep), .port_access(port_access),
		.port_clk_en(port_clk_en), .port_bus_fault(port_bus_fault),
		.can_unit_reset(can_unit_reset), .watchdog_reset(watchdog_reset),
		.irq(irq));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			n_fail++;
			$display("mismatch %0t seen %h want %h", $time, s, e);
		end
	endtask
	// One single AHB transfer; reads note their expectation
	task ahb(input logic w, input logic [11:0] a, input logic [31:0] dd, e);
		@(posedge clk_sys);  // Every drive starts just after an edge
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge clk_sys);
		while (!hready) @(posedge clk_sys);
		htrans <= 2'h0;
		hwdata <= dd;
		if (!w) exp_q.push_back(e);
		@(posedge clk_sys);
		while (!hready) @(posedge clk_sys);
	endtask
	// Set power mode, let enables settle, compare them
	task mode(input logic s, input logic dp, input logic [7:0] e);
		sys_sleep <= s;
		sys_deep_sleep <= dp;
		repeat (2) @(posedge clk_sys);
		#1 chk(port_clk_en, e);
	endtask
	// Strobe ports once and look at the fault pulse
	task poke(input logic [7:0] v, input logic e);
		@(posedge clk_sys);
		port_access <= v;
		@(posedge clk_sys);
		port_access <= 0;
		#1 chk(port_bus_fault, e);
	endtask
	task results;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ----------------------------------------
	// Read watcher: data phase ends, oldest note compared
	// ----------------------------------------
	always @(posedge clk_sys)
	begin
		if (rd_ph) chk(hrdata, exp_q.pop_front());
		rd_ph <= hsel && hready && htrans[1] && !hwrite;
	end
	// Watchdog well beyond the two hundred or so cycles needed
	initial
	begin
		#200000;
		n_fail++;
		results;
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		d = $urandom(18);
		repeat (10) @(posedge clk_sys);
		sys_rst <= 0;
		@(posedge clk_sys);
		ahb(0, 12'h128, 0, 0);
		ahb(0, 12'h040, 0, 0);
		ahb(0, 12'h200, 0, 0);
		// Random word: reserved upper bits must drop
		d = $urandom;
		ahb(1, 12'h128, d, 0);
		ahb(0, 12'h128, 0, d & 32'hff);
		ahb(1, 12'h060, 1, 0);
		ahb(0, 12'h060, 0, 1);
		for (i = 0; i < 8; i++)
		begin
			ahb(1, 12'h128, 32'h1 << i, 0);
			mode(0, 1, 8'h1 << i);
		end
		ahb(1, 12'h118, 32'h5a, 0);
		ahb(0, 12'h118, 0, 32'h5a);
		mode(1, 0, 8'h5a);
		ahb(1, 12'h108, 32'hc3, 0);
		ahb(0, 12'h108, 0, 32'hc3);
		mode(0, 0, 8'hc3);
		ahb(1, 12'h060, 0, 0);
		mode(0, 1, 8'hc3);
		ahb(1, 12'h060, 1, 0);
		ahb(1, 12'h128, 32'h1, 0);
		mode(0, 1, 8'h01);
		mode(1, 1, 8'h01);
		// Fault event raises, is cleared, then masked
		ahb(1, 12'h154, 1, 0);
		ahb(0, 12'h154, 0, 1);
		poke(8'h02, 1);
		poke(8'h01, 0);
		repeat (2) @(posedge clk_sys);
		#1 chk(irq, 1);
		ahb(1, 12'h150, 3, 0);
		repeat (2) @(posedge clk_sys);
		#1 chk(irq, 0);
		ahb(1, 12'h154, 0, 0);
		poke(8'h80, 1);
		repeat (2) @(posedge clk_sys);
		#1 chk(irq, 0);
		// Soft resets under every capability pattern
		for (i = 0; i < 4; i++)
		begin
			c = {7'h0, i[1], 20'h0, i[0], 3'h0};
			@(posedge clk_sys);
			capabilities_1 <= c;
			ahb(1, 12'h040, 32'hffff_ffff, 0);
			#1 chk(can_unit_reset, c[24]);
			chk(watchdog_reset, c[3]);
			ahb(0, 12'h040, 0, c);
			ahb(1, 12'h040, 0, 0);
			#1 chk({can_unit_reset, watchdog_reset}, 0);
		end
		// Masked fault from port H plus raised resets, irq stays low
		ahb(0, 12'h150, 0, 32'h3);
		#1 chk(irq, 0);
		results;
	end
endmodule
